//--- rtl/rev_defines.vh
// Register offsets, field positions, reset values and vector codes
// for the receive error and interrupt vectoring block.
`ifndef REV_DEFINES_VH
`define REV_DEFINES_VH

// Register offsets (word addresses on the processor register port)
`define REV_ADDR_VECTOR_HIGH_BYTE   4'h1
`define REV_ADDR_IRQ_SELECT_MASK    4'h2
`define REV_ADDR_FILL_PATTERN       4'h3
`define REV_ADDR_RX_ERROR_STATUS    4'h4
`define REV_ADDR_CONTROL            4'h8
`define REV_ADDR_EVENT_STATUS       4'h9
`define REV_ADDR_EVENT_ENABLE       4'ha
`define REV_ADDR_EVENT_CLEAR        4'hb
`define REV_ADDR_VECTOR_LOW         4'hc
`define REV_ADDR_VECTOR_HIGH        4'hd

// Receive error status fields
`define REV_ERR_RX_OFF_BIT          0
`define REV_ERR_MIDBIT_BIT          1
`define REV_ERR_ENDING_BIT          2
`define REV_ERR_PARITY_BIT          3
`define REV_ERR_OVERRUN_BIT         4

// Select and mask fields
`define REV_SEL_RSV_BIT             5
`define REV_SEL_RXSRC_LSB           6
`define REV_SEL_BIDIR_MASK_BIT      3

// Control register fields
`define REV_CTL_ERR_SELECT_BIT      0
`define REV_CTL_BIDIR_OUT_BIT       1

// Reset values
`define REV_RST_BYTE                8'h00
`define REV_RST_SEL_MASK            8'h00

// Receiver interrupt select codes
`define REV_RXSRC_FULL              2'b00
`define REV_RXSRC_AVAIL             2'b01

// Vector source codes
`define REV_VEC_NMI                 6'h1c
`define REV_VEC_RX                  6'h04
`define REV_VEC_TX                  6'h08
`define REV_VEC_LTA                 6'h0c
`define REV_VEC_BIDIR               6'h10
`define REV_VEC_TIMER               6'h14

// Receive word count at which a further frame overflows
`define REV_FIFO_WORDS              2'd3

// Event status bits
`define REV_EVT_ERROR               0
`define REV_EVT_OVERFLOW            1
`define REV_EVT_VECTOR              2

`endif

//--- rtl/rev_vector_arbiter.v
// Fixed priority arbiter building the interrupt vector word.
// Assumes pending and mask inputs are already registered.
`timescale 1ns/10ps
`include "rev_defines.vh"

module rev_vector_arbiter (
  input  wire [7:0]  base_byte,
  input  wire        nmi_pending,
  input  wire [4:0]  src_pending,
  input  wire [4:0]  src_mask,
  output reg         vec_valid,
  output reg  [15:0] vec_word
);

  reg [4:0] live;
  reg [5:0] code;

  always @* begin
    live      = src_pending & ~src_mask;
    code      = 6'h00;
    vec_valid = 1'b1;
    // NMI bypasses ranking and masking
    if (nmi_pending) begin
      code = `REV_VEC_NMI;
    end else if (live[0]) begin
      code = `REV_VEC_RX;
    end else if (live[1]) begin
      code = `REV_VEC_TX;
    end else if (live[2]) begin
      code = `REV_VEC_LTA;
    end else if (live[3]) begin
      code = `REV_VEC_BIDIR;
    end else if (live[4]) begin
      code = `REV_VEC_TIMER;
    end else begin
      vec_valid = 1'b0;
    end
    vec_word = {base_byte, 2'b00, code};
  end

endmodule // rev_vector_arbiter

//--- rtl/rev_core.v
// Receive error capture, interrupt select/mask registers and vectoring.
// Assumes error strobes from the receiver are one-cycle pulses on clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "rev_defines.vh"

// Operation
// - Overflow flag sets when a frame completes with three words unread and no buffer read that cycle.
// - Parity flag sets on any frame with odd overall parity.
// - Invalid-ending flag sets on bad closing code violation in those modes.
// - Lost-mid-bit flag sets when mid-bit transition misses its window.
// - Receiver-disabled flag sets when transmit starts on active receive unprotected.
// - All error flags clear on status read or transceiver reset.
// - Error status is read only, visible at offset 4 while select high.
// - Vector high byte comes from the base register.
// - Vector is base byte, two zeros, six-bit source code.
// - Receiver highest, then transmitter, turnaround, bidirectional, timer.
// - Select field 00 full-or-error, 01 available-or-error, 10 unused.
// - Bit 5 of select register is reserved, reads undefined.
// - Each mask bit high suppresses its own source.
// - Mask bit 3 drives bidirectional pin when that pin is output.
module rev_core (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        frame_done,
  input  wire [1:0]  rx_words_unread,
  input  wire        rx_buffer_read,
  input  wire        frame_parity_odd,
  input  wire        ending_check_mode,
  input  wire        ending_bad,
  input  wire        mid_bit_missing,
  input  wire        tx_start,
  input  wire        rx_active,
  input  wire        receiver_protect_enable,
  input  wire        transceiver_reset_bit,
  input  wire        receive_buffer_full,
  input  wire        data_available,
  input  wire        nmi_req,
  input  wire        tx_irq,
  input  wire        lta_irq,
  input  wire        bidir_irq_in,
  input  wire        timer_irq,
  output reg         bidirectional_irq_pin_o,
  output reg         bidirectional_irq_pin_oe,
  output reg         irq_req,
  output reg  [15:0] irq_vector,
  output reg         irq_out
);

  // ********************************
  // Registers
  // ********************************
  reg [7:0]  vector_high_byte_r;
  reg [7:0]  sel_mask_r;
  reg [7:0]  fill_pattern_r;
  reg [4:0]  err_r;
  reg [1:0]  ctl_r;
  reg [2:0]  evt_r;
  reg [2:0]  evt_en_r;
  reg        rsv_toggle_r;
  wire       wr_vec_base;
  wire       wr_sel_mask;
  wire       wr_fill;
  wire       wr_control;
  wire       wr_evt_enable;
  reg [4:0]  err_nxt;
  reg [2:0]  evt_nxt;
  reg [4:0]  err_set;
  reg [7:0]  rdata_nxt;
  reg        rx_src;
  wire       vec_valid;
  wire [15:0] vec_word;
  wire [4:0] mask_eff;
  wire [4:0] pending;
  wire       err_sel;
  wire       bidir_out;
  wire       err_read;

  function hit;
    input [3:0] a;
    input [3:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign err_sel   = ctl_r[`REV_CTL_ERR_SELECT_BIT];
  assign bidir_out = ctl_r[`REV_CTL_BIDIR_OUT_BIT];
  assign err_read  = reg_rd && err_sel && hit(reg_addr, `REV_ADDR_RX_ERROR_STATUS);
  assign wr_vec_base   = reg_wr && hit(reg_addr, `REV_ADDR_VECTOR_HIGH_BYTE);
  assign wr_sel_mask   = reg_wr && hit(reg_addr, `REV_ADDR_IRQ_SELECT_MASK);
  assign wr_fill       = reg_wr && hit(reg_addr, `REV_ADDR_FILL_PATTERN);
  assign wr_control    = reg_wr && hit(reg_addr, `REV_ADDR_CONTROL);
  assign wr_evt_enable = reg_wr && hit(reg_addr, `REV_ADDR_EVENT_ENABLE);

  // ********************************
  // Error capture
  // ********************************
  always @* begin
    err_set = 5'h00;
    // Third word unread and another frame lands before any read
    err_set[`REV_ERR_OVERRUN_BIT] = frame_done && (rx_words_unread == `REV_FIFO_WORDS)
                                    && !rx_buffer_read;
    err_set[`REV_ERR_PARITY_BIT]  = frame_done && frame_parity_odd;
    err_set[`REV_ERR_ENDING_BIT]  = ending_check_mode && ending_bad;
    err_set[`REV_ERR_MIDBIT_BIT]  = mid_bit_missing;
    err_set[`REV_ERR_RX_OFF_BIT]  = tx_start && rx_active && !receiver_protect_enable;
    err_nxt = err_r;
    if (err_read || transceiver_reset_bit) begin
      err_nxt = 5'h00;
    end
    // New error beats a simultaneous clear so it is not lost
    err_nxt = err_nxt | err_set;
  end

  // ********************************
  // Receiver source and masks
  // ********************************
  always @* begin
    case (sel_mask_r[`REV_SEL_RXSRC_LSB+1:`REV_SEL_RXSRC_LSB])
      `REV_RXSRC_FULL:  rx_src = receive_buffer_full || (err_r != 5'h00);
      `REV_RXSRC_AVAIL: rx_src = data_available || (err_r != 5'h00);
      default:        rx_src = 1'b0;
    endcase
  end

  // Mask bit 3 only masks while the bidirectional pin is an input
  assign mask_eff = {sel_mask_r[4], sel_mask_r[3] & ~bidir_out, sel_mask_r[2:0]};
  assign pending  = {timer_irq, bidir_out ? 1'b0 : bidir_irq_in, lta_irq, tx_irq, rx_src};

  rev_vector_arbiter u_arb (
    .base_byte   (vector_high_byte_r),
    .nmi_pending (nmi_req),
    .src_pending (pending),
    .src_mask    (mask_eff),
    .vec_valid   (vec_valid),
    .vec_word    (vec_word)
  );

  // ********************************
  // Event status
  // ********************************
  always @* begin
    evt_nxt = evt_r;
    if (reg_wr && hit(reg_addr, `REV_ADDR_EVENT_CLEAR)) begin
      evt_nxt = evt_r & ~reg_wdata[2:0];
    end
    evt_nxt[`REV_EVT_ERROR]    = evt_nxt[`REV_EVT_ERROR] | (err_set != 5'h00);
    evt_nxt[`REV_EVT_OVERFLOW] = evt_nxt[`REV_EVT_OVERFLOW] | err_set[`REV_ERR_OVERRUN_BIT];
    evt_nxt[`REV_EVT_VECTOR]   = evt_nxt[`REV_EVT_VECTOR] | (vec_valid & ~irq_req);
  end

  // ********************************
  // Read mux
  // ********************************
  always @* begin
    rdata_nxt = 8'h00;
    if (hit(reg_addr, `REV_ADDR_VECTOR_HIGH_BYTE)) begin
      rdata_nxt = vector_high_byte_r;
    end else if (hit(reg_addr, `REV_ADDR_IRQ_SELECT_MASK)) begin
      rdata_nxt = sel_mask_r;
      // Reserved bit reads a free-running toggle, not the stored value
      rdata_nxt[`REV_SEL_RSV_BIT] = rsv_toggle_r;
    end else if (hit(reg_addr, `REV_ADDR_FILL_PATTERN)) begin
      rdata_nxt = fill_pattern_r;
    end else if (hit(reg_addr, `REV_ADDR_RX_ERROR_STATUS)) begin
      rdata_nxt = err_sel ? {3'b000, err_r} : 8'h00;
    end else if (hit(reg_addr, `REV_ADDR_CONTROL)) begin
      rdata_nxt = {6'h00, ctl_r};
    end else if (hit(reg_addr, `REV_ADDR_EVENT_STATUS)) begin
      rdata_nxt = {5'h00, evt_r};
    end else if (hit(reg_addr, `REV_ADDR_EVENT_ENABLE)) begin
      rdata_nxt = {5'h00, evt_en_r};
    end else if (hit(reg_addr, `REV_ADDR_VECTOR_LOW)) begin
      rdata_nxt = irq_vector[7:0];
    end else if (hit(reg_addr, `REV_ADDR_VECTOR_HIGH)) begin
      rdata_nxt = irq_vector[15:8];
    end
  end

  // ********************************
  // Software registers
  // ********************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_high_byte_r <= `REV_RST_BYTE;
    end else if (wr_vec_base) begin
      vector_high_byte_r <= reg_wdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_mask_r <= `REV_RST_SEL_MASK;
    end else if (wr_sel_mask) begin
      sel_mask_r <= reg_wdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fill_pattern_r <= `REV_RST_BYTE;
    end else if (wr_fill) begin
      fill_pattern_r <= reg_wdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= 2'b00;
    end else if (wr_control) begin
      ctl_r <= reg_wdata[1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_en_r <= 3'b000;
    end else if (wr_evt_enable) begin
      evt_en_r <= reg_wdata[2:0];
    end
  end

  // ********************************
  // Flags and events
  // ********************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r <= 5'h00;
    end else begin
      err_r <= err_nxt;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_r <= 3'b000;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsv_toggle_r <= 1'b0;
    end else begin
      rsv_toggle_r <= ~rsv_toggle_r;
    end
  end

  // ********************************
  // Read data
  // ********************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bidirectional_irq_pin_o <= 1'b0;
    end else begin
      bidirectional_irq_pin_o <= bidir_out & sel_mask_r[`REV_SEL_BIDIR_MASK_BIT];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bidirectional_irq_pin_oe <= 1'b0;
    end else begin
      bidirectional_irq_pin_oe <= bidir_out;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= vec_valid;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_vector <= 16'h0000;
    end else begin
      irq_vector <= vec_word;
    end
  end

  // Next status used so the line rises with its status bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_nxt & evt_en_r);
    end
  end

endmodule // rev_core

//--- verif/rev_rx_model.sv
// Line-side receiver stand-in: turns one bench request into one-cycle event pulses.
// Assumes kind and fire change just after a rising edge.
`timescale 1ns/10ps
module rev_rx_model (
  input  logic       clk,
  input  logic       reset_n,
  input  logic [2:0] kind,
  input  logic       fire,
  output logic       frame_done,
  output logic [1:0] rx_words_unread,
  output logic       rx_buffer_read,
  output logic       frame_parity_odd,
  output logic       ending_bad,
  output logic       mid_bit_missing,
  output logic       tx_start,
  output logic       rx_active
);
  // Kinds: 0 overrun, 1 odd parity, 2 bad ending, 3 lost mid-bit,
  // 4 transmit over live receive, 5 clean frame, 6 full buffer read in time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {frame_done, rx_buffer_read, frame_parity_odd, ending_bad} <= 4'h0;
      {mid_bit_missing, tx_start, rx_active} <= 3'h0;
      rx_words_unread <= 2'h0;
    end else begin
      frame_done <= fire && (kind <= 3'd1 || kind >= 3'd5);
      rx_words_unread <= (fire && (kind == 3'd0 || kind == 3'd6)) ? 2'h3 : 2'h0;
      rx_buffer_read <= fire && kind == 3'd6;
      frame_parity_odd <= fire && kind == 3'd1;
      ending_bad <= fire && kind == 3'd2;
      mid_bit_missing <= fire && kind == 3'd3;
      tx_start <= fire && kind == 3'd4;
      rx_active <= fire && kind == 3'd4;
    end
  end
endmodule // rev_rx_model

//--- verif/rev_core_checker.sv
// Checker for the receive error and vector block; sees rev_core ports only.
// Select and mask shadows assume the register port is their only writer.
`timescale 1ns/10ps
module rev_core_checker (
  input logic        clk,
  input logic        reset_n,
  input logic [3:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  input logic        frame_done,
  input logic [1:0]  rx_words_unread,
  input logic        rx_buffer_read,
  input logic        nmi_req,
  input logic        bidirectional_irq_pin_o,
  input logic        bidirectional_irq_pin_oe,
  input logic        irq_req,
  input logic [15:0] irq_vector
);
  logic [7:0] sel_r, ctl_r;
  logic [1:0] quiet_r;
  logic       rx_ok, overrun_ev, unmapped;
  // Outputs are trusted only three edges after the last select/mask or control write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= 8'h00;
      ctl_r <= 8'h00;
      quiet_r <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h2) sel_r <= reg_wdata;
      if (reg_wr && reg_addr == 4'h8) ctl_r <= reg_wdata;
      if (reg_wr && (reg_addr == 4'h2 || reg_addr == 4'h8)) quiet_r <= 2'h0;
      else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
    end
  end
  assign rx_ok = quiet_r == 2'h3 && !sel_r[0] && sel_r[7:6] == 2'b00 && !nmi_req;
  assign overrun_ev = frame_done && rx_words_unread == 2'h3 && !rx_buffer_read;
  assign unmapped = reg_addr inside {4'h0, 4'h5, 4'h6, 4'h7, 4'he, 4'hf};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property ($past(reg_rd && unmapped) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  err_sel_a: assert property (quiet_r == 2'h3 && $past(reg_rd && reg_addr == 4'h4 && !ctl_r[0]) |-> reg_rdata == 8'h00)
    else $error("error status seen while deselected");
  vec_fmt_a: assert property (irq_req |-> irq_vector[7:6] == 2'b00 && irq_vector[1:0] == 2'b00)
    else $error("vector padding bits not zero");
  nmi_code_a: assert property (nmi_req ##1 nmi_req |-> irq_req && irq_vector[5:0] == 6'h1c)
    else $error("non-maskable vector wrong");
  mask_all_a: assert property (quiet_r == 2'h3 && sel_r[4:0] == 5'h1f && !nmi_req && !$past(nmi_req) |-> !irq_req)
    else $error("request with all sources masked");
  overrun_irq_a: assert property (rx_ok && overrun_ev |-> ##[1:3] irq_req && irq_vector[5:0] == 6'h04)
    else $error("overrun gave no receiver request");
  pin_oe_a: assert property (quiet_r == 2'h3 |-> bidirectional_irq_pin_oe == ctl_r[1])
    else $error("pin enable does not follow direction");
  pin_lvl_a: assert property (quiet_r == 2'h3 && ctl_r[1] |-> bidirectional_irq_pin_o == sel_r[3])
    else $error("pin level does not follow mask bit 3");
  cover property (rx_ok && overrun_ev);
  cover property (irq_req && irq_vector[5:0] == 6'h1c);
  cover property (bidirectional_irq_pin_oe && bidirectional_irq_pin_o);
endmodule // rev_core_checker

//--- verif/rx_error_and_interrupt_vectoring_tb_top.sv
// Self-checking bench for rev_core: register tasks, line event stand-in, vector checks.
// Assumes one 100 MHz clock and the register map of the design header.
`timescale 1ns/10ps
module rx_error_and_interrupt_vectoring_tb_top;
  logic        clk, reset_n, reg_wr, reg_rd, fire, ecm, rx_protect, xcvr_reset, data_avail, nmi;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  kind;
  logic [4:0]  srcs;
  logic [1:0]  rx_words_unread;
  logic [15:0] irq_vector;
  logic        frame_done, rx_buffer_read, frame_parity_odd, ending_bad, mid_bit_missing, tx_start, rx_active;
  logic        bidirectional_irq_pin_o, bidirectional_irq_pin_oe, irq_req, irq_out;
  int          mismatches, samples_checked;
  rev_core uut (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_done, .rx_words_unread,
    .rx_buffer_read, .frame_parity_odd, .ending_check_mode(ecm), .ending_bad, .mid_bit_missing, .tx_start,
    .rx_active, .receiver_protect_enable(rx_protect), .transceiver_reset_bit(xcvr_reset),
    .receive_buffer_full(srcs[0]), .data_available(data_avail), .nmi_req(nmi), .tx_irq(srcs[1]),
    .lta_irq(srcs[2]), .bidir_irq_in(srcs[3]),
    .timer_irq(srcs[4]), .bidirectional_irq_pin_o, .bidirectional_irq_pin_oe, .irq_req, .irq_vector, .irq_out
  );
  rev_rx_model model (
    .clk, .reset_n, .kind, .fire, .frame_done, .rx_words_unread, .rx_buffer_read, .frame_parity_odd,
    .ending_bad, .mid_bit_missing, .tx_start, .rx_active
  );
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Mask hides bits whose value is undefined or not under test
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, reg_rdata & m});
  endtask
  task automatic ev(input logic [2:0] k);
    @(posedge clk);
    kind <= k;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, fire, rx_protect, xcvr_reset, data_avail, nmi} = '0;
    {reg_addr, reg_wdata, kind, srcs} = '0;
    ecm = 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h2, 8'h00, 8'hdf);
    wr(4'h1, 8'h5a);
    wr(4'h3, 8'hc3);
    wr(4'h5, 8'hff);
    rd(4'h1, 8'h5a, 8'hff);
    rd(4'h3, 8'hc3, 8'hff);
    rd(4'h5, 8'h00, 8'hff);
    wr(4'h8, 8'h01);
    for (int k = 0; k < 5; k++) begin
      ev(3'(k));
      rd(4'h4, 8'h10 >> k, 8'h1f);
      rd(4'h4, 8'h00, 8'h1f);
    end
    // Near misses: drained buffer, clean frame, protected transmit, ending check off
    ev(3'd6);
    ev(3'd5);
    rx_protect <= 1'b1;
    ev(3'd4);
    ecm <= 1'b0;
    ev(3'd2);
    rd(4'h4, 8'h00, 8'h1f);
    {ecm, rx_protect} <= 2'b10;
    ev(3'd1);
    ev(3'd5);
    rd(4'h4, 8'h08, 8'h1f);
    ev(3'd1);
    xcvr_reset <= 1'b1;
    @(posedge clk);
    xcvr_reset <= 1'b0;
    rd(4'h4, 8'h00, 8'h1f);
    wr(4'h8, 8'h00);
    ev(3'd1);
    rd(4'h4, 8'h00, 8'hff);
    wr(4'h8, 8'h01);
    // Overrun, error and new-vector events all seen since reset
    rd(4'h9, 8'h07, 8'hff);
    wr(4'hb, 8'h07);
    ev(3'd3);
    rd(4'h9, 8'h01, 8'h07);
    chk("irq_out", 16'h0, {15'h0, irq_out});
    wr(4'ha, 8'h01);
    settle;
    chk("irq_out", 16'h1, {15'h0, irq_out});
    rd(4'h4, 8'h0a, 8'h1f);
    wr(4'hb, 8'h01);
    settle;
    chk("irq_out", 16'h0, {15'h0, irq_out});
    // All maskable sources pending; masking the top ones walks down the ranking
    srcs <= 5'h1f;
    for (int i = 0; i < 5; i++) begin
      wr(4'h2, 8'((1 << i) - 1));
      settle;
      rd(4'hc, 8'(4 * (i + 1)), 8'hff);
      rd(4'hd, 8'h5a, 8'hff);
    end
    wr(4'h2, 8'h1f);
    settle;
    chk("irq_req", 16'h0, {15'h0, irq_req});
    nmi <= 1'b1;
    settle;
    rd(4'hc, 8'h1c, 8'hff);
    nmi <= 1'b0;
    srcs <= 5'h00;
    data_avail <= 1'b1;
    wr(4'h2, 8'h40);
    settle;
    rd(4'hc, 8'h04, 8'hff);
    wr(4'h2, 8'h80);
    settle;
    chk("irq_req", 16'h0, {15'h0, irq_req});
    wr(4'h2, 8'h00);
    settle;
    chk("irq_req", 16'h0, {15'h0, irq_req});
    wr(4'h8, 8'h02);
    wr(4'h2, 8'h08);
    srcs <= 5'h08;
    settle;
    chk("pin", 16'h3, {14'h0, bidirectional_irq_pin_oe, bidirectional_irq_pin_o});
    chk("irq_req", 16'h0, {15'h0, irq_req});
    wr(4'h2, 8'h00);
    settle;
    chk("pin", 16'h2, {14'h0, bidirectional_irq_pin_oe, bidirectional_irq_pin_o});
    tally_and_finish;
  end
endmodule // rx_error_and_interrupt_vectoring_tb_top
bind rev_core rev_core_checker chk (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_done, .rx_words_unread,
  .rx_buffer_read, .nmi_req, .bidirectional_irq_pin_o, .bidirectional_irq_pin_oe, .irq_req, .irq_vector
);
